// ---- hw/pwm_fault_lock_pkg.sv ----
// shared constants for the six-output motor pwm with fault and write lock
package pwm_fault_lock_pkg;
  // =====================================================================
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFS_TB_CTL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_CTL_ONE = 8'h08;
  localparam logic [7:0] OFS_FLT_A = 8'h0C;
  localparam logic [7:0] OFS_FLT_B = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_DUTY0 = 8'h18;
  localparam logic [7:0] OFS_DUTY1 = 8'h1C;
  localparam logic [7:0] OFS_DUTY2 = 8'h20;
  localparam logic [7:0] OFS_SEVT = 8'h24;
  localparam logic [7:0] OFS_OVR = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  // =====================================================================
  // field positions
  localparam int TB_EN_POS = 15;
  localparam int TB_MODE_LSB = 0;
  localparam int CTL_PEN_LSB = 0;
  localparam int CTL_INDEP_LSB = 4;
  localparam int CTL_IMM_POS = 8;
  localparam int FLT_DRV_LSB = 0;
  localparam int FLT_LVL_LSB = 6;
  localparam int FLT_CYC_POS = 14;
  localparam int FLT_EN_POS = 15;
  localparam int OVR_EN_LSB = 0;
  localparam int OVR_VAL_LSB = 8;
  localparam int LOCK_CFG_POS = 6;
  // =====================================================================
  // reset values
  localparam logic [15:0] TB_CTL_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] CTL_ONE_RST = 16'h0000;
  localparam logic [15:0] FLT_RST = 16'h803F;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] SEVT_RST = 16'h0000;
  localparam logic [15:0] OVR_RST = 16'h0000;
  // =====================================================================
  // unlock keys and bus answers
  localparam logic [15:0] KEY_FIRST = 16'hABCD;
  localparam logic [15:0] KEY_SECOND = 16'h4321;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =====================================================================
  // time base modes
  localparam logic [1:0] MODE_EDGE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CENTER = 2'h2;
  typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} unlock_t;
endpackage

// ---- hw/motor_pwm_fault_lock.sv ----
// motor pwm generator with fault forcing and keyed write protection
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
// Function
// - three duty generators drive three high/low pairs, six outputs.
// - complementary pair drives low output as inverse of its high output.
// - time base and duty compare are sixteen bits wide.
// - edge-aligned or center-aligned waveforms chosen by configuration.
// - single-pulse mode gives one pulse then stops the time base.
// - duty updates immediate or held to the time base boundary.
// - special-event compare on the time base emits a trigger pulse.
// - center mode signals half period so duties update asymmetrically.
// - override control lets software force each output.
// - two fault inputs; either one forces outputs to safe state.
// - per output, a fault optionally drives a configured level.
// - after reset both faults are enabled, latched and flagged.
// - latched fault releases only with pin high and flag cleared.
// - outputs restored at next period or half-period boundary.
// - control one and both fault controls blocked while lock active.
// - lock config bit six at zero disables protection permanently.
// - only the very next access after the keys may write through.
// - each unlock grants at most one protected write; a read or other access uses it up.
module motor_pwm_fault_lock (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration word, static after reset
  input wire logic [7:0] osc_select_config_word,
  // fault pins, low is asserted
  input wire logic fault_input_a,
  input wire logic fault_input_b,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power stage
  output logic [2:0] high_side_output,
  output logic [2:0] low_side_output,
  // events to other peripherals
  output logic special_event_trigger,
  output logic half_period_event
);
  // =====================================================================
  // declarations
  logic [15:0] tb_ctl_r, period_r, ctl_one_r, sevt_r, ovr_r;
  logic [15:0] flt_ctl_r [2];
  logic [15:0] duty_r [3];
  logic [15:0] duty_act_r [3];
  logic [15:0] tb_cnt_r;
  logic tb_down_r;
  logic cfg_lock_r, cfg_taken_r;
  pwm_fault_lock_pkg::unlock_t unl_r;
  logic [2:0] flt_sync_r [2];
  logic [1:0] flt_lvl_r, flt_flag_r, flt_act_r, flt_cond;
  logic [1:0] flt_clr;
  logic wr_go, rd_go, wr_prot, wr_ok;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  logic tb_en, per_bnd, half_bnd, bnd;
  logic [2:0] pwm_h;
  logic [5:0] pin_nxt;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] val, input logic [1:0] strb);
    merge16 = {strb[1] ? val[15:8] : old[15:8],
               strb[0] ? val[7:0] : old[7:0]};
  endfunction

  // protected register decode, used only by the write response
  function automatic logic is_prot(input logic [7:0] a);
    is_prot = (a == pwm_fault_lock_pkg::OFS_CTL_ONE) ||
              (a == pwm_fault_lock_pkg::OFS_FLT_A) ||
              (a == pwm_fault_lock_pkg::OFS_FLT_B);
  endfunction

  // mapped-address decode for both channels
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) &&
                (a <= pwm_fault_lock_pkg::OFS_STATUS);
  endfunction

  // =====================================================================
  // axi4-lite handshakes: one access at a time, writes first
  assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_go = s_axi_arready && s_axi_arvalid;
  assign wr_addr = s_axi_awaddr;
  assign wr_data = s_axi_wdata[15:0];
  assign wr_strb = s_axi_wstrb[1:0];

  // ready pulses once both halves of a write are offered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid && !s_axi_arready && !s_axi_rvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                      !s_axi_bvalid && !s_axi_arready && !s_axi_rvalid;
      s_axi_arready <= s_axi_arvalid && !(s_axi_awvalid && s_axi_wvalid) &&
                       !s_axi_arready && !s_axi_awready &&
                       !s_axi_bvalid && !s_axi_rvalid;
    end
  end

  // write response; a refused protected write answers slverr
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwm_fault_lock_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (is_mapped(wr_addr) && (!wr_prot || wr_ok)) ?
                     pwm_fault_lock_pkg::RESP_OKAY :
                     pwm_fault_lock_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data; key reads zero, unmapped answers slverr
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pwm_fault_lock_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ?
                     pwm_fault_lock_pkg::RESP_OKAY :
                     pwm_fault_lock_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        pwm_fault_lock_pkg::OFS_TB_CTL: s_axi_rdata <= {16'h0000, tb_ctl_r};
        pwm_fault_lock_pkg::OFS_PERIOD: s_axi_rdata <= {16'h0000, period_r};
        pwm_fault_lock_pkg::OFS_CTL_ONE: s_axi_rdata <= {16'h0000, ctl_one_r};
        pwm_fault_lock_pkg::OFS_FLT_A: s_axi_rdata <= {16'h0000, flt_ctl_r[0]};
        pwm_fault_lock_pkg::OFS_FLT_B: s_axi_rdata <= {16'h0000, flt_ctl_r[1]};
        pwm_fault_lock_pkg::OFS_DUTY0: s_axi_rdata <= {16'h0000, duty_r[0]};
        pwm_fault_lock_pkg::OFS_DUTY1: s_axi_rdata <= {16'h0000, duty_r[1]};
        pwm_fault_lock_pkg::OFS_DUTY2: s_axi_rdata <= {16'h0000, duty_r[2]};
        pwm_fault_lock_pkg::OFS_SEVT: s_axi_rdata <= {16'h0000, sevt_r};
        pwm_fault_lock_pkg::OFS_OVR: s_axi_rdata <= {16'h0000, ovr_r};
        pwm_fault_lock_pkg::OFS_STATUS: s_axi_rdata <= {24'h000000,
            tb_down_r, cfg_lock_r, unl_r == pwm_fault_lock_pkg::UNL_OPEN,
            tb_en, flt_act_r, flt_flag_r};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================================
  // write lock
  // config bit caught once after reset release, then held for good
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_lock_r <= 1'b1; // protected by default
      cfg_taken_r <= 1'b0;
    end else if (!cfg_taken_r) begin
      cfg_lock_r <=
          osc_select_config_word[pwm_fault_lock_pkg::LOCK_CFG_POS];
      cfg_taken_r <= 1'b1;
    end
  end

  assign wr_prot = is_prot(wr_addr);
  assign wr_ok = !cfg_lock_r ||
                 (unl_r == pwm_fault_lock_pkg::UNL_OPEN);

  // key sequencer; every register access, read or write, advances it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unl_r <= pwm_fault_lock_pkg::UNL_IDLE;
    end else if (wr_go || rd_go) begin
      if (wr_go && wr_addr == pwm_fault_lock_pkg::OFS_KEY &&
          unl_r == pwm_fault_lock_pkg::UNL_KEY1 &&
          wr_data == pwm_fault_lock_pkg::KEY_SECOND) begin
        unl_r <= pwm_fault_lock_pkg::UNL_OPEN;
      end else if (wr_go && wr_addr == pwm_fault_lock_pkg::OFS_KEY &&
                   wr_data == pwm_fault_lock_pkg::KEY_FIRST) begin
        unl_r <= pwm_fault_lock_pkg::UNL_KEY1;
      end else begin
        unl_r <= pwm_fault_lock_pkg::UNL_IDLE;
      end
    end
  end

  // =====================================================================
  // register writes; protected ones pass only when unlocked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_one_r <= pwm_fault_lock_pkg::CTL_ONE_RST;
      flt_ctl_r[0] <= pwm_fault_lock_pkg::FLT_RST;
      flt_ctl_r[1] <= pwm_fault_lock_pkg::FLT_RST;
    end else if (wr_go && wr_ok) begin
      if (wr_addr == pwm_fault_lock_pkg::OFS_CTL_ONE)
        ctl_one_r <= merge16(ctl_one_r, wr_data, wr_strb);
      if (wr_addr == pwm_fault_lock_pkg::OFS_FLT_A)
        flt_ctl_r[0] <= merge16(flt_ctl_r[0], wr_data, wr_strb);
      if (wr_addr == pwm_fault_lock_pkg::OFS_FLT_B)
        flt_ctl_r[1] <= merge16(flt_ctl_r[1], wr_data, wr_strb);
    end
  end

  // free registers; single-pulse end clears the enable unless written
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tb_ctl_r <= pwm_fault_lock_pkg::TB_CTL_RST;
      period_r <= pwm_fault_lock_pkg::PERIOD_RST;
      sevt_r <= pwm_fault_lock_pkg::SEVT_RST;
      ovr_r <= pwm_fault_lock_pkg::OVR_RST;
      for (int i = 0; i < 3; i++) duty_r[i] <= pwm_fault_lock_pkg::DUTY_RST;
    end else begin
      if (tb_en && per_bnd && tb_ctl_r[1:0] == pwm_fault_lock_pkg::MODE_SINGLE)
        tb_ctl_r[pwm_fault_lock_pkg::TB_EN_POS] <= 1'b0;
      if (wr_go) begin
        unique case (wr_addr)
          pwm_fault_lock_pkg::OFS_TB_CTL:
            tb_ctl_r <= merge16(tb_ctl_r, wr_data, wr_strb);
          pwm_fault_lock_pkg::OFS_PERIOD:
            period_r <= merge16(period_r, wr_data, wr_strb);
          pwm_fault_lock_pkg::OFS_DUTY0:
            duty_r[0] <= merge16(duty_r[0], wr_data, wr_strb);
          pwm_fault_lock_pkg::OFS_DUTY1:
            duty_r[1] <= merge16(duty_r[1], wr_data, wr_strb);
          pwm_fault_lock_pkg::OFS_DUTY2:
            duty_r[2] <= merge16(duty_r[2], wr_data, wr_strb);
          pwm_fault_lock_pkg::OFS_SEVT:
            sevt_r <= merge16(sevt_r, wr_data, wr_strb);
          pwm_fault_lock_pkg::OFS_OVR:
            ovr_r <= merge16(ovr_r, wr_data, wr_strb);
          default: ;
        endcase
      end
    end
  end

  // =====================================================================
  // time base: up-count edge/single, up-down center
  assign tb_en = tb_ctl_r[pwm_fault_lock_pkg::TB_EN_POS];
  assign per_bnd = (tb_ctl_r[1:0] == pwm_fault_lock_pkg::MODE_CENTER) ?
                   (tb_down_r && tb_cnt_r == 16'h0000) :
                   (tb_cnt_r >= period_r);
  assign half_bnd = (tb_ctl_r[1:0] == pwm_fault_lock_pkg::MODE_CENTER) &&
                    !tb_down_r && (tb_cnt_r >= period_r);
  assign bnd = !tb_en || per_bnd || half_bnd;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tb_cnt_r <= 16'h0000;
      tb_down_r <= 1'b0;
    end else if (!tb_en) begin
      tb_cnt_r <= 16'h0000;
      tb_down_r <= 1'b0;
    end else if (tb_ctl_r[1:0] == pwm_fault_lock_pkg::MODE_CENTER) begin
      if (half_bnd) begin
        tb_down_r <= 1'b1;
        tb_cnt_r <= tb_cnt_r - 16'h0001;
      end else if (per_bnd) begin
        tb_down_r <= 1'b0;
        tb_cnt_r <= 16'h0001;
      end else begin
        tb_cnt_r <= tb_down_r ? tb_cnt_r - 16'h0001 : tb_cnt_r + 16'h0001;
      end
    end else begin
      // a stale down flag from center mode would mute the special event
      tb_down_r <= 1'b0;
      tb_cnt_r <= per_bnd ? 16'h0000 : tb_cnt_r + 16'h0001;
    end
  end

  // event pulses; half-period only exists in center mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      special_event_trigger <= 1'b0;
      half_period_event <= 1'b0;
    end else begin
      special_event_trigger <= tb_en && !tb_down_r &&
                               tb_cnt_r == sevt_r;
      half_period_event <= tb_en && half_bnd;
    end
  end

  // =====================================================================
  // duty generators with shadowed or immediate update
  generate
    for (genvar g = 0; g < 3; g++) begin : g_duty
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
          duty_act_r[g] <= pwm_fault_lock_pkg::DUTY_RST;
        else if (ctl_one_r[pwm_fault_lock_pkg::CTL_IMM_POS] || bnd)
          duty_act_r[g] <= duty_r[g];
      end
      assign pwm_h[g] = tb_en && (tb_cnt_r < duty_act_r[g]);
    end
  endgenerate

  // =====================================================================
  // fault inputs: three-stage sync, accepted when stages two and three agree
  assign flt_clr = (wr_go && wr_addr == pwm_fault_lock_pkg::OFS_STATUS &&
                    wr_strb[0]) ? wr_data[1:0] : 2'b00;
  generate
    for (genvar k = 0; k < 2; k++) begin : g_flt
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          flt_sync_r[k] <= 3'b000;
          flt_lvl_r[k] <= 1'b0; // pin counted low, fault asserted
        end else begin
          flt_sync_r[k] <= {flt_sync_r[k][1:0],
                            k == 0 ? fault_input_a : fault_input_b};
          if (flt_sync_r[k][1] == flt_sync_r[k][2])
            flt_lvl_r[k] <= flt_sync_r[k][2];
        end
      end
      // flag: set wins over a write-one clear while the pin stays low
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
          flt_flag_r[k] <= 1'b1;
        else if (flt_ctl_r[k][pwm_fault_lock_pkg::FLT_EN_POS] && !flt_lvl_r[k])
          flt_flag_r[k] <= 1'b1;
        else if (flt_clr[k])
          flt_flag_r[k] <= 1'b0;
      end
      assign flt_cond[k] = flt_ctl_r[k][pwm_fault_lock_pkg::FLT_EN_POS] &&
          (flt_ctl_r[k][pwm_fault_lock_pkg::FLT_CYC_POS] ?
           !flt_lvl_r[k] : flt_flag_r[k]);
      // forcing starts at once, ends only on a boundary
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
          flt_act_r[k] <= 1'b1;
        else if (flt_cond[k])
          flt_act_r[k] <= 1'b1;
        else if (bnd)
          flt_act_r[k] <= 1'b0;
      end
    end
  endgenerate

  // =====================================================================
  // pin mux: fault a, then fault b, then override, then pwm
  always_comb begin
    for (int j = 0; j < 6; j++) begin
      if (j < 3)
        pin_nxt[j] = pwm_h[j];
      else if (ctl_one_r[pwm_fault_lock_pkg::CTL_INDEP_LSB + j - 3])
        pin_nxt[j] = pwm_h[j-3];
      else
        pin_nxt[j] = !pwm_h[j-3];
      if (!ctl_one_r[pwm_fault_lock_pkg::CTL_PEN_LSB + (j % 3)])
        pin_nxt[j] = 1'b0; // disabled pair stays inactive
      if (ovr_r[pwm_fault_lock_pkg::OVR_EN_LSB + j])
        pin_nxt[j] = ovr_r[pwm_fault_lock_pkg::OVR_VAL_LSB + j];
      if (flt_act_r[1] && flt_ctl_r[1][pwm_fault_lock_pkg::FLT_DRV_LSB + j])
        pin_nxt[j] = flt_ctl_r[1][pwm_fault_lock_pkg::FLT_LVL_LSB + j];
      if (flt_act_r[0] && flt_ctl_r[0][pwm_fault_lock_pkg::FLT_DRV_LSB + j])
        pin_nxt[j] = flt_ctl_r[0][pwm_fault_lock_pkg::FLT_LVL_LSB + j];
    end
  end

  // outputs registered so the power stage sees no decode glitches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_side_output <= 3'h0;
      low_side_output <= 3'h0;
    end else begin
      high_side_output <= pin_nxt[2:0];
      low_side_output <= pin_nxt[5:3];
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_compl;
    (ctl_one_r[0] && !ctl_one_r[4] && ovr_r[3:0] == 4'h0 &&
     flt_act_r == 2'b00) |=> (low_side_output[0] == !high_side_output[0]);
  endproperty
  a_compl: assert property (p_compl)
    else $error("pair0 not complementary");

  property p_fault_level;
    (flt_act_r[0] && flt_ctl_r[0][0]) |=>
      (high_side_output[0] == $past(flt_ctl_r[0][6]));
  endproperty
  a_fault_level: assert property (p_fault_level)
    else $error("fault level");

  property p_restore;
    $fell(flt_act_r[0]) |-> $past(bnd);
  endproperty
  a_restore: assert property (p_restore) else $error("early restore");

  property p_set_wins;
    (flt_ctl_r[1][15] && !flt_lvl_r[1] && flt_clr[1]) |=> flt_flag_r[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost");

  property p_blocked;
    (wr_go && wr_addr == pwm_fault_lock_pkg::OFS_CTL_ONE && cfg_lock_r &&
     unl_r != pwm_fault_lock_pkg::UNL_OPEN) |=> $stable(ctl_one_r);
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("locked write passed");

  sequence s_open_used;
    unl_r == pwm_fault_lock_pkg::UNL_OPEN && (wr_go || rd_go);
  endsequence
  property p_one_shot;
    s_open_used |=> unl_r != pwm_fault_lock_pkg::UNL_OPEN;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("unlock reused");

  // last taken access was the first key; idle gaps do not break the pair
  logic key1_seen_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      key1_seen_r <= 1'b0;
    else if (wr_go || rd_go)
      key1_seen_r <= wr_go && wr_addr == pwm_fault_lock_pkg::OFS_KEY &&
                     wr_data == pwm_fault_lock_pkg::KEY_FIRST;
  end
  sequence s_second_key;
    wr_go && wr_addr == pwm_fault_lock_pkg::OFS_KEY &&
    wr_data == pwm_fault_lock_pkg::KEY_SECOND;
  endsequence
  sequence s_keys;
    key1_seen_r ##0 s_second_key;
  endsequence
  property p_unlock;
    s_keys |=> unl_r == pwm_fault_lock_pkg::UNL_OPEN;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("keys did not unlock");

  property p_sevt;
    (tb_en && !tb_down_r && tb_cnt_r == sevt_r) |=> special_event_trigger;
  endproperty
  a_sevt: assert property (p_sevt) else $error("special event missed");

  property p_bresp;
    wr_go |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response");
endmodule

// ---- tb/fault_circuit_model.sv ----
// fault detection circuit model driving the two fault pins
`timescale 1ns/10ps
module fault_circuit_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bench commands that trip each fault
  input wire logic trip_a,
  input wire logic trip_b,
  // fault pins, low means fault
  output logic fault_input_a,
  output logic fault_input_b
);
  // pins sit low in reset, as an undriven pulled-down line would
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_input_a <= 1'b0;
      fault_input_b <= 1'b0;
    end else begin
      fault_input_a <= ~trip_a;
      fault_input_b <= ~trip_b;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the motor pwm with fault lock
`timescale 1ns/10ps
module testbench;
  // ====================================================================
  // clock, reset and wiring
  logic clk = 0, arst_n = 0, trip_a = 0, trip_b = 0;
  logic [7:0] cfg = 8'h40, awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, v;
  wire awready, wready, bvalid, arready, rvalid, fa, fb, sev, hev;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] hi, lo;
  int num_errors = 0, checks_done = 0, k, n;
  always #12.5 clk = ~clk;
  fault_circuit_model flt_u (.clk(clk), .arst_n(arst_n), .trip_a(trip_a),
    .trip_b(trip_b), .fault_input_a(fa), .fault_input_b(fb));
  motor_pwm_fault_lock dut_u (.clk(clk), .arst_n(arst_n),
    .osc_select_config_word(cfg), .fault_input_a(fa), .fault_input_b(fb),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .high_side_output(hi),
    .low_side_output(lo), .special_event_trigger(sev),
    .half_period_event(hev));
  // ====================================================================
  // verdict, compare and bounded-wait helpers
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang(input int c);
    if (c >= 60) begin
      num_errors++;
      $display("ERROR %0t wait bound used up", $time);
      test_done();
    end
  endtask
  // one axi4-lite write; response code lands in v
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int c;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      c++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && c < 60);
    hang(c);
    v = {30'h0, bresp};
    bready <= 1'b0;
  endtask
  // one axi4-lite read; response in v[31:30], data below
  task automatic rd(input logic [7:0] a);
    int c;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      c++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && c < 60);
    hang(c);
    v = {rresp, rdata[29:0]};
    rready <= 1'b0;
  endtask
  task automatic key(input logic [15:0] d);
    wr(pwm_fault_lock_pkg::OFS_KEY, d);
  endtask
  // ====================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(pwm_fault_lock_pkg::OFS_STATUS);
    chk(v, 32'h0000004F);
    rd(pwm_fault_lock_pkg::OFS_FLT_A);
    chk(v, 32'h0000803F);
    wr(pwm_fault_lock_pkg::OFS_CTL_ONE, 16'h0007);
    chk(v, pwm_fault_lock_pkg::RESP_SLVERR);
    key(pwm_fault_lock_pkg::KEY_FIRST);
    key(pwm_fault_lock_pkg::KEY_SECOND);
    wr(pwm_fault_lock_pkg::OFS_FLT_A, 16'h0000);
    chk(v, pwm_fault_lock_pkg::RESP_OKAY);
    wr(pwm_fault_lock_pkg::OFS_FLT_A, 16'h0001);
    chk(v, pwm_fault_lock_pkg::RESP_SLVERR);
    // key sequence broken by a read, then by a wrong key value
    for (k = 0; k < 2; k++) begin
      key(pwm_fault_lock_pkg::KEY_FIRST);
      if (k == 0) rd(pwm_fault_lock_pkg::OFS_STATUS);
      else key(16'h1234);
      key(pwm_fault_lock_pkg::KEY_SECOND);
      wr(pwm_fault_lock_pkg::OFS_FLT_A, 16'h0002);
      chk(v, pwm_fault_lock_pkg::RESP_SLVERR);
    end
    rd(pwm_fault_lock_pkg::OFS_FLT_A);
    chk(v, 32'h0);
    // clear attempt with pin still low must not stick
    trip_b <= 1'b1;
    repeat (8) @(posedge clk);
    wr(pwm_fault_lock_pkg::OFS_STATUS, 16'h0003);
    rd(pwm_fault_lock_pkg::OFS_STATUS);
    chk(v[1], 1'b1);
    trip_b <= 1'b0;
    repeat (8) @(posedge clk);
    wr(pwm_fault_lock_pkg::OFS_STATUS, 16'h0003);
    rd(pwm_fault_lock_pkg::OFS_STATUS);
    chk(v, 32'h00000040);
    // edge mode, period 9 gives 10 counts, duty 4 high
    wr(pwm_fault_lock_pkg::OFS_PERIOD, 16'h0009);
    wr(pwm_fault_lock_pkg::OFS_DUTY0, 16'h0004);
    wr(pwm_fault_lock_pkg::OFS_SEVT, 16'h0003);
    wr(pwm_fault_lock_pkg::OFS_TB_CTL, 16'h8000);
    key(pwm_fault_lock_pkg::KEY_FIRST);
    key(pwm_fault_lock_pkg::KEY_SECOND);
    wr(pwm_fault_lock_pkg::OFS_CTL_ONE, 16'h0007);
    chk(v, pwm_fault_lock_pkg::RESP_OKAY);
    for (k = 0; k < 60 && sev !== 1'b1; k++) @(posedge clk);
    hang(k);
    repeat (12) @(posedge clk);
    n = 0;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      n += hi[0];
      chk({29'h0, lo}, {29'h0, ~hi});
    end
    chk(n, 8);
    // override holds high side 0 high through a whole period
    wr(pwm_fault_lock_pkg::OFS_OVR, 16'h0101);
    repeat (2) @(posedge clk);
    for (k = 0; k < 10; k++) begin
      @(posedge clk);
      chk(hi[0], 1'b1);
    end
    wr(pwm_fault_lock_pkg::OFS_OVR, 16'h0000);
    // fault b forces every pin to zero and stays latched
    trip_b <= 1'b1;
    for (k = 0; k < 60 && {hi, lo} !== 6'h00; k++) @(posedge clk);
    hang(k);
    trip_b <= 1'b0;
    repeat (10) @(posedge clk);
    chk({hi, lo}, 6'h00);
    wr(pwm_fault_lock_pkg::OFS_STATUS, 16'h0002);
    for (k = 0; k < 60 && lo !== ~hi; k++) @(posedge clk);
    hang(k);
    wr(pwm_fault_lock_pkg::OFS_TB_CTL, 16'h8002);
    for (k = 0; k < 60 && hev !== 1'b1; k++) @(posedge clk);
    hang(k);
    wr(pwm_fault_lock_pkg::OFS_TB_CTL, 16'h8001);
    repeat (40) @(posedge clk);
    rd(pwm_fault_lock_pkg::OFS_STATUS);
    chk(v[4], 1'b0);
    rd(8'h30);
    chk(v[31:30], pwm_fault_lock_pkg::RESP_SLVERR);
    // second reset with the lock configuration bit at zero
    arst_n <= 1'b0;
    cfg <= 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    wr(pwm_fault_lock_pkg::OFS_CTL_ONE, 16'h0007);
    chk(v, pwm_fault_lock_pkg::RESP_OKAY);
    test_done();
  end
endmodule
